//--- core/vcc_pkg.sv
// package for the voltage comparator control block
// holds the register map, field positions, reset values and carrier types
// assumes an 8-bit register port shared with other peripherals
`default_nettype none

package vcc_pkg;

  // ==========================================================================
  // register port widths
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam logic [7:0] MODE_ADDR = 8'h9D; // comparator_mode_select
  localparam logic [7:0] CTRL_ADDR = 8'hC0; // enable, routing, live result
  localparam logic [7:0] STAT_ADDR = 8'hC1; // sticky edge events
  localparam logic [7:0] MASK_ADDR = 8'hC2; // interrupt mask

  // ==========================================================================
  // mode register fields
  // ==========================================================================
  localparam int MODE_RISE_BIT = 5; // rise_irq_en
  localparam int MODE_FALL_BIT = 4; // fall_irq_en
  localparam int MODE_SEL_LSB = 0; // speed_power_sel[1:0]
  localparam logic [7:0] MODE_WMASK = 8'h33; // writable bits
  localparam logic [7:0] MODE_RESET = 8'h02;

  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int CTRL_EN_BIT = 7; // comparator enable and power
  localparam int CTRL_SYNC_BIT = 6; // live synchronised result, read only
  localparam int CTRL_RSTSEL_BIT = 2; // comparator as reset source
  localparam int CTRL_ROUTE_BIT = 1; // pin carries a comparator result
  localparam int CTRL_PPULL_BIT = 0; // 1 push-pull, 0 open-drain
  localparam int CTRL_RAWSEL_BIT = 3; // 1 pin gets raw, 0 pin gets sync
  localparam logic [7:0] CTRL_WMASK = 8'h8F;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================================
  // status and mask fields
  // ==========================================================================
  localparam int EVT_RISE_BIT = 1;
  localparam int EVT_FALL_BIT = 0;
  localparam logic [1:0] EVT_RESET = 2'h0;

  // ==========================================================================
  // carrier types
  // ==========================================================================
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } vcc_bus_req_s;

  typedef struct packed {
    logic out;
    logic oe;
  } vcc_pin_s;

endpackage : vcc_pkg

`default_nettype wire

//--- core/vcc_comparator_control.sv
// digital control around an on-chip voltage comparator
// assumes the comparator's digital output arrives on cmpIn, possibly
// asynchronous; register strobes are synchronous to clk

`timescale 1ns/1ps
`default_nettype none

module vcc_comparator_control #(
  parameter int ADDR_W = vcc_pkg::ADDR_W,
  parameter int DATA_W = vcc_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire vcc_pkg::vcc_bus_req_s busReq,
  output logic [DATA_W-1:0] rdData,
  input wire logic cmpIn,
  output logic cmpPowerEn,
  output logic [1:0] speedPowerSel,
  output logic rawCmpOut,
  output logic syncCmpOut,
  output vcc_pkg::vcc_pin_s cmpPin,
  output logic rstSrcSel,
  output logic rstSrcLevel,
  output logic irq
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  // the map and field layout assume an 8-bit port
  if (ADDR_W != 8 || DATA_W != 8) begin : g_bad_width
    $error("vcc_comparator_control supports 8-bit address and data only");
  end

  // ==========================================================================
  // register state
  // ==========================================================================
  logic [7:0] modeReg;
  logic [7:0] ctrlReg;
  logic [1:0] evtStat;
  logic [1:0] evtMask;
  logic cmpMeta;
  logic prevCmp;
  logic [1:0] edgeHit;
  logic statRead;
  logic cmpEnable;
  logic gatedCmp;
  logic pinValue;

  // address decode, a write strobe for mode, control and mask and a read strobe for status
  logic wrMode;
  logic wrCtrl;
  logic wrMask;
  assign wrMode = busReq.wr && (busReq.addr == vcc_pkg::MODE_ADDR);
  assign wrCtrl = busReq.wr && (busReq.addr == vcc_pkg::CTRL_ADDR);
  assign wrMask = busReq.wr && (busReq.addr == vcc_pkg::MASK_ADDR);
  assign statRead = busReq.rd && (busReq.addr == vcc_pkg::STAT_ADDR);

  // mode register keeps only its writable bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeReg <= vcc_pkg::MODE_RESET;
    end else if (wrMode) begin
      modeReg <= busReq.wdata & vcc_pkg::MODE_WMASK;
    end
  end

  // control register: enable, routing, output mode, reset select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlReg <= vcc_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrlReg <= busReq.wdata & vcc_pkg::CTRL_WMASK;
    end
  end

  // interrupt mask, same layout as the status bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evtMask <= vcc_pkg::EVT_RESET;
    end else if (wrMask) begin
      evtMask <= busReq.wdata[1:0];
    end
  end

  // ==========================================================================
  // comparator power and mode
  // ==========================================================================
  // power follows the enable bit; the analog macro reads the mode field
  assign cmpEnable = ctrlReg[vcc_pkg::CTRL_EN_BIT];
  assign cmpPowerEn = cmpEnable;
  assign speedPowerSel = modeReg[vcc_pkg::MODE_SEL_LSB +: 2];

  // ==========================================================================
  // raw and synchronised result paths
  // ==========================================================================
  // raw path is pure gating, so it lives on while clk is stopped
  assign gatedCmp = cmpIn & cmpEnable;
  assign rawCmpOut = gatedCmp;

  // two-flop synchroniser; only the second flop is looked at
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmpMeta <= 1'b0;
      syncCmpOut <= 1'b0;
    end else begin
      cmpMeta <= gatedCmp;
      syncCmpOut <= cmpMeta;
    end
  end

  // previous synchronised sample for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevCmp <= 1'b0;
    end else begin
      prevCmp <= syncCmpOut;
    end
  end

  // qualified edges, one request per edge
  always_comb begin
    edgeHit = 2'h0;
    edgeHit[vcc_pkg::EVT_RISE_BIT] = syncCmpOut && !prevCmp &&
      modeReg[vcc_pkg::MODE_RISE_BIT];
    edgeHit[vcc_pkg::EVT_FALL_BIT] = !syncCmpOut && prevCmp &&
      modeReg[vcc_pkg::MODE_FALL_BIT];
  end

  // ==========================================================================
  // interrupt status
  // ==========================================================================
  // read clears, but an edge in the same cycle stays set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evtStat <= vcc_pkg::EVT_RESET;
    end else if (statRead) begin
      evtStat <= edgeHit;
    end else begin
      evtStat <= evtStat | edgeHit;
    end
  end

  // level interrupt while any unmasked event is pending
  assign irq = |(evtStat & evtMask);

  // ==========================================================================
  // port pin drive
  // ==========================================================================
  // pin picks raw or synchronised result; forced low while disabled, as
  // the synchroniser may still hold a high level for two cycles
  assign pinValue = cmpEnable &&
    (ctrlReg[vcc_pkg::CTRL_RAWSEL_BIT] ? gatedCmp : syncCmpOut);

  // push-pull drives both levels, open-drain only pulls low
  always_comb begin
    cmpPin.out = 1'b0;
    cmpPin.oe = 1'b0;
    if (ctrlReg[vcc_pkg::CTRL_ROUTE_BIT]) begin
      if (ctrlReg[vcc_pkg::CTRL_PPULL_BIT]) begin
        cmpPin.out = pinValue;
        cmpPin.oe = 1'b1;
      end else begin
        cmpPin.out = 1'b0;
        cmpPin.oe = !pinValue;
      end
    end
  end

  // ==========================================================================
  // reset source hook
  // ==========================================================================
  // reset logic sees the raw result and the select bit
  assign rstSrcSel = ctrlReg[vcc_pkg::CTRL_RSTSEL_BIT];
  assign rstSrcLevel = gatedCmp;

  // ==========================================================================
  // read data, one cycle after the read strobe
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= 8'h00;
    end else if (busReq.rd) begin
      case (busReq.addr)
        vcc_pkg::MODE_ADDR: rdData <= modeReg;
        vcc_pkg::CTRL_ADDR: begin
          rdData <= ctrlReg;
          rdData[vcc_pkg::CTRL_SYNC_BIT] <= syncCmpOut;
        end
        vcc_pkg::STAT_ADDR: rdData <= {6'h00, evtStat};
        vcc_pkg::MASK_ADDR: rdData <= {6'h00, evtMask};
        default: rdData <= 8'h00;
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // input held for three cycles reaches the synchronised output
  sequence s_cmp_high3;
    (cmpIn && cmpEnable)[*3];
  endsequence

  sequence s_cmp_low3;
    (!cmpIn || !cmpEnable)[*3];
  endsequence

  chk_sync_follow_high: assert property (
    s_cmp_high3 |-> syncCmpOut)
    else $error("synchronised result missed a steady high input");

  chk_sync_follow_low: assert property (
    s_cmp_low3 |-> !syncCmpOut)
    else $error("synchronised result missed a steady low input");

  chk_raw_when_on: assert property (
    cmpEnable |-> (rawCmpOut == cmpIn) && (rstSrcLevel == cmpIn))
    else $error("raw result does not follow the comparator");

  chk_off_forced_low: assert property (
    !cmpEnable |-> !rawCmpOut && !cmpPowerEn &&
      !(cmpPin.oe && cmpPin.out))
    else $error("disabled comparator still drives a high level");

  chk_off_sync_low: assert property (
    !cmpEnable [*3] |-> !syncCmpOut && !cmpPin.out)
    else $error("synchronised result not low after disable");

  // rising flag appears only when enabled and a rise was seen
  chk_rise_qualified: assert property (
    $rose(evtStat[vcc_pkg::EVT_RISE_BIT]) |->
      $past(modeReg[vcc_pkg::MODE_RISE_BIT]) && $past(syncCmpOut) &&
      !$past(prevCmp))
    else $error("rising event without an enabled rising edge");

  chk_fall_qualified: assert property (
    $rose(evtStat[vcc_pkg::EVT_FALL_BIT]) |->
      $past(modeReg[vcc_pkg::MODE_FALL_BIT]) && !$past(syncCmpOut) &&
      $past(prevCmp))
    else $error("falling event without an enabled falling edge");

  sequence s_enabled_rise;
    !syncCmpOut ##1 (syncCmpOut && modeReg[vcc_pkg::MODE_RISE_BIT]);
  endsequence

  chk_rise_flagged: assert property (
    s_enabled_rise ##1 1'b1 |-> evtStat[vcc_pkg::EVT_RISE_BIT])
    else $error("enabled rising edge did not set its flag");

  chk_speed_write: assert property (
    wrMode |=> speedPowerSel == $past(busReq.wdata[1:0]))
    else $error("speed and power field not taken from the write");

  chk_mode_unused: assert property (
    busReq.rd && busReq.addr == vcc_pkg::MODE_ADDR |=>
      rdData[7:6] == 2'h0 && rdData[3:2] == 2'h0)
    else $error("unused mode bits read back non-zero");

  chk_irq_clear: assert property (
    statRead && edgeHit == 2'h0 |=> !irq && evtStat == 2'h0)
    else $error("status read did not clear the interrupt");

  chk_pin_mode: assert property (
    ctrlReg[vcc_pkg::CTRL_ROUTE_BIT] |->
      (ctrlReg[vcc_pkg::CTRL_PPULL_BIT] ? cmpPin.oe
                                        : (cmpPin.oe == !pinValue)))
    else $error("routed pin drive does not match its output mode");

  chk_reset_hook: assert property (
    wrCtrl |=> rstSrcSel == $past(busReq.wdata[vcc_pkg::CTRL_RSTSEL_BIT]))
    else $error("reset source select not taken from the write");

  // a disabled comparator pulls its routed pin low at once
  chk_off_pin_low: assert property (
    !cmpEnable && ctrlReg[vcc_pkg::CTRL_ROUTE_BIT] |->
      cmpPin.oe && !cmpPin.out)
    else $error("disabled comparator does not hold its pin low");

  // routed push-pull pin carries the selected result while enabled
  chk_pin_raw: assert property (
    cmpEnable && ctrlReg[vcc_pkg::CTRL_ROUTE_BIT] &&
      ctrlReg[vcc_pkg::CTRL_PPULL_BIT] && ctrlReg[vcc_pkg::CTRL_RAWSEL_BIT]
      |-> cmpPin.out == rawCmpOut)
    else $error("routed pin does not carry the raw result");

  chk_pin_sync: assert property (
    cmpEnable && ctrlReg[vcc_pkg::CTRL_ROUTE_BIT] &&
      ctrlReg[vcc_pkg::CTRL_PPULL_BIT] && !ctrlReg[vcc_pkg::CTRL_RAWSEL_BIT]
      |-> cmpPin.out == syncCmpOut)
    else $error("routed pin does not carry the synchronised result");

  sequence s_enabled_fall;
    syncCmpOut ##1 (!syncCmpOut && modeReg[vcc_pkg::MODE_FALL_BIT]);
  endsequence

  chk_fall_flagged: assert property (
    s_enabled_fall ##1 1'b1 |-> evtStat[vcc_pkg::EVT_FALL_BIT])
    else $error("enabled falling edge did not set its flag");

  // an edge whose enable is clear leaves a clear flag clear
  chk_rise_refused: assert property (
    !modeReg[vcc_pkg::MODE_RISE_BIT] && !evtStat[vcc_pkg::EVT_RISE_BIT] |=>
      !evtStat[vcc_pkg::EVT_RISE_BIT])
    else $error("rising edge set its flag while disabled");

  chk_fall_refused: assert property (
    !modeReg[vcc_pkg::MODE_FALL_BIT] && !evtStat[vcc_pkg::EVT_FALL_BIT] |=>
      !evtStat[vcc_pkg::EVT_FALL_BIT])
    else $error("falling edge set its flag while disabled");

  // flags stay set until a status read takes them
  chk_flag_sticky: assert property (
    !statRead && evtStat != 2'h0 |=> (evtStat & $past(evtStat)) ==
      $past(evtStat))
    else $error("event flag dropped without a status read");

  // read data stand only in the cycle after the read strobe
  chk_rd_idle: assert property (
    !busReq.rd |=> rdData == 8'h00)
    else $error("read data present without a read strobe");

  // control read shows the live synchronised result
  chk_ctrl_live: assert property (
    busReq.rd && busReq.addr == vcc_pkg::CTRL_ADDR |=>
      rdData[vcc_pkg::CTRL_SYNC_BIT] == $past(syncCmpOut))
    else $error("control read lacks the live result");

endmodule : vcc_comparator_control

`default_nettype wire

//--- verif/vcc_cmp_model.sv
// far-side model: analog comparator output and the port line it drives
// assumes the line carries a pull-up, so an open-drain high reads high
`timescale 1ns/1ps
`default_nettype none

module vcc_cmp_model (
  input wire logic clk,
  input wire logic powerEn,
  input wire logic level,
  input wire vcc_pkg::vcc_pin_s cmpPin,
  output logic cmpIn,
  output logic pinWire
);
  logic junk = 1'b0;

  // ==========================================================================
  // comparator output
  // ==========================================================================
  // unpowered comparator gives a changing value, never a clean level
  always @(posedge clk) begin
    junk <= ~junk;
  end
  assign cmpIn = powerEn ? level : junk;

  // ==========================================================================
  // port line
  // ==========================================================================
  // pull-up wins whenever nobody drives the line
  assign pinWire = cmpPin.oe ? cmpPin.out : 1'b1;
endmodule : vcc_cmp_model

`default_nettype wire

//--- verif/voltage_comparator_control_tb.sv
// self-checking bench for the voltage comparator control block
// assumes the register map and field layout of vcc_pkg
`timescale 1ns/1ps
`default_nettype none

module voltage_comparator_control_tb;
  logic clk = 1'b0;
  logic clkRun = 1'b1;
  logic rst = 1'b1;
  vcc_pkg::vcc_bus_req_s busReq = '0;
  logic [7:0] rdData;
  logic cmpIn, cmpPowerEn, rawCmpOut, syncCmpOut, rstSrcSel, rstSrcLevel, irq;
  logic [1:0] speedPowerSel;
  vcc_pkg::vcc_pin_s cmpPin;
  logic cmdLevel = 1'b0;
  logic pinWire;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  // ==========================================================================
  // clock, timeout, instances
  // ==========================================================================
  // clock can be stopped to exercise the clockless raw path
  always #50 if (clkRun) clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  vcc_comparator_control u_dut (.clk(clk), .rst(rst), .busReq(busReq),
    .rdData(rdData), .cmpIn(cmpIn), .cmpPowerEn(cmpPowerEn),
    .speedPowerSel(speedPowerSel), .rawCmpOut(rawCmpOut),
    .syncCmpOut(syncCmpOut), .cmpPin(cmpPin), .rstSrcSel(rstSrcSel),
    .rstSrcLevel(rstSrcLevel), .irq(irq));

  vcc_cmp_model u_model (.clk(clk), .powerEn(cmpPowerEn), .level(cmdLevel),
    .cmpPin(cmpPin), .cmpIn(cmpIn), .pinWire(pinWire));

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string name);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    chk(name, exp, rdData);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // new comparator level, then time for sync and flag
  task automatic setCmp(input logic v);
    @(posedge clk);
    cmdLevel <= v;
    settle(5);
  endtask : setCmp

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(vcc_pkg::MODE_ADDR, 8'h02, "mode reset");
    chk("speed reset", 8'h02, speedPowerSel);
    rd(vcc_pkg::CTRL_ADDR, 8'h00, "ctrl reset");
    rd(vcc_pkg::STAT_ADDR, 8'h00, "status reset");
    rd(vcc_pkg::MASK_ADDR, 8'h00, "mask reset");
    rd(8'h10, 8'h00, "unmapped");
    wr(vcc_pkg::MODE_ADDR, 8'hFF);
    rd(vcc_pkg::MODE_ADDR, 8'h33, "mode unused");
    for (int i = 0; i < 4; i++) begin
      wr(vcc_pkg::MODE_ADDR, 8'(i));
      #1;
      chk("speed", 8'(i), speedPowerSel);
    end
    // disabled comparator holds the routed pin low
    wr(vcc_pkg::CTRL_ADDR, 8'h03);
    setCmp(1'b1);
    chk("power off", 8'h00, cmpPowerEn);
    chk("pin off", 8'h00, pinWire);
    chk("raw off", 8'h00, rawCmpOut);
    // enabling with input high gives a rising edge
    wr(vcc_pkg::MASK_ADDR, 8'h03);
    wr(vcc_pkg::MODE_ADDR, 8'h20);
    wr(vcc_pkg::CTRL_ADDR, 8'h83);
    settle(5);
    chk("sync", 8'h01, syncCmpOut);
    chk("pin push", 8'h03, {cmpPin.out, cmpPin.oe});
    chk("irq rise", 8'h01, irq);
    rd(vcc_pkg::CTRL_ADDR, 8'hC3, "ctrl live");
    rd(vcc_pkg::STAT_ADDR, 8'h02, "stat rise");
    chk("irq clear", 8'h00, irq);
    setCmp(1'b0);
    rd(vcc_pkg::STAT_ADDR, 8'h00, "fall off");
    wr(vcc_pkg::MODE_ADDR, 8'h10);
    setCmp(1'b1);
    rd(vcc_pkg::STAT_ADDR, 8'h00, "rise off");
    setCmp(1'b0);
    rd(vcc_pkg::STAT_ADDR, 8'h01, "stat fall");
    // masked event is recorded but raises no interrupt
    wr(vcc_pkg::MASK_ADDR, 8'h00);
    setCmp(1'b1);
    setCmp(1'b0);
    chk("irq masked", 8'h00, irq);
    rd(vcc_pkg::STAT_ADDR, 8'h01, "stat masked");
    // open-drain routing
    wr(vcc_pkg::CTRL_ADDR, 8'h82);
    setCmp(1'b1);
    chk("od high", 8'h00, {cmpPin.out, cmpPin.oe});
    chk("od wire hi", 8'h01, pinWire);
    setCmp(1'b0);
    chk("od low", 8'h01, {cmpPin.out, cmpPin.oe});
    chk("od wire lo", 8'h00, pinWire);
    // raw result on the pin with the clock stopped
    wr(vcc_pkg::CTRL_ADDR, 8'h8B);
    settle(2);
    clkRun = 1'b0;
    #500 cmdLevel = 1'b1;
    #500 chk("raw stop hi", 8'h01, rawCmpOut);
    chk("raw pin hi", 8'h01, pinWire);
    cmdLevel = 1'b0;
    #500 chk("raw stop lo", 8'h00, rawCmpOut);
    chk("raw pin lo", 8'h00, pinWire);
    clkRun = 1'b1;
    // comparator offered as reset source
    wr(vcc_pkg::CTRL_ADDR, 8'h84);
    setCmp(1'b1);
    chk("rst sel", 8'h01, rstSrcSel);
    chk("rst level", 8'h01, rstSrcLevel);
    // disabling pulls the pin low before the synchroniser drains
    wr(vcc_pkg::CTRL_ADDR, 8'h83);
    settle(2);
    wr(vcc_pkg::CTRL_ADDR, 8'h03);
    #1;
    chk("pin drop", 8'h00, pinWire);
    chk("sync drain", 8'h01, syncCmpOut);
    conclude();
  end
endmodule : voltage_comparator_control_tb

`default_nettype wire
